// ### rtl/twbc_core.sv
// two-wire bus controller core: master/slave byte engine with register port
//
// Local design decisions: the strobed register port and the address map.
`include "twbc_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module twbc_core (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  // processor side
  input  wire logic       global_int_en,
  output var  logic       irq,
  output var  logic       wake_req,
  // bus pins
  input  wire logic       scl_i,
  output wire logic       scl_o,
  output var  logic       scl_oe_b,
  input  wire logic       sda_i,
  output wire logic       sda_o,
  output var  logic       sda_oe_b
);

  localparam int FD = `TWBC_FILT_DEPTH;

  twbc_pkg::twbc_state_t state;
  logic [7:0]  bit_rate, own_addr, shift_data, pend_code, status_q;
  logic [1:0]  ps_sel;
  logic        ack_en, sta, sto, en, ie, flag;
  logic [3:0]  bit_cnt;
  logic        master, addressed, addr_phase, rd_dir, arb_lost, gc, ack_rx;
  logic        scl_rel, sda_low, ph, rs, busy;
  logic [14:0] tmr;
  logic [1:0]  sy1, sy2, filt, prev;
  logic [FD-1:0] hist [2];

  // each pin: two-flop synchroniser, then a glitch filter
  generate
    for (genvar i = 0; i < 2; i++) begin : g_pin
      always_ff @(posedge core_clk) begin
        if (!rst_b) begin
          sy1[i]  <= 1'b1;
          sy2[i]  <= 1'b1;
          hist[i] <= '1;
          filt[i] <= 1'b1;
          prev[i] <= 1'b1;
        end else begin
          sy1[i]  <= (i == 0) ? scl_i : sda_i;
          sy2[i]  <= sy1[i];
          hist[i] <= {hist[i][FD-2:0], sy2[i]};
          prev[i] <= filt[i];
          // level must hold for more than the spike width
          if (&hist[i])
            filt[i] <= 1'b1;
          else if (~|hist[i])
            filt[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // edges are only resolvable if scl stays at or below clk/16
  wire scl_f     = filt[0];
  wire sda_f     = filt[1];
  wire scl_rise  = scl_f & ~prev[0];
  wire scl_fall  = ~scl_f & prev[0];
  wire start_det = scl_f & prev[0] & prev[1] & ~sda_f;
  wire stop_det  = scl_f & prev[0] & ~prev[1] & sda_f;

  // bit-rate generator, only for master phases
  wire [6:0]  ps_val = 7'h01 << {ps_sel, 1'b0};
  wire [14:0] half_m1 = 15'(`TWBC_HALF_BASE + bit_rate * ps_val - 15'h0001);
  wire gen_run = en & master & ~flag & (state != twbc_pkg::st_idle) &
                 (state != twbc_pkg::st_hold);
  // released scl still low after the sampling delay means a slave stretches
  wire stall   = scl_rel & ~scl_f & (tmr >= 15'(`TWBC_SYNC_LAT));
  wire tmr_end = gen_run & ~stall & (tmr == half_m1);

  always_ff @(posedge core_clk) begin
    if (!rst_b || !gen_run || tmr_end)
      tmr <= 15'h0000;
    else if (!stall)
      tmr <= tmr + 15'h0001;
  end

  // address match, usable while the processor sleeps
  wire own_hit  = shift_data[7:1] == own_addr[7:1];
  wire gc_hit   = own_addr[`TWBC_O_GCE] & (shift_data[7:1] == 7'h00) &
                  ~shift_data[0];
  wire match_ok = ack_en & (own_hit | gc_hit);

  wire is_tx  = master ? (addr_phase | ~rd_dir) : rd_dir;
  wire ack_ok = ~ack_rx;
  wire arb_hit = master & is_tx & (bit_cnt < 4'h8) & ~sda_low & ~sda_f;
  wire bus_err = (start_det | stop_det) & (state == twbc_pkg::st_xfer) &
                 (bit_cnt != 4'h0) & (master | addressed);

  // status after a packet carries the ack seen or sent
  wire [7:0] evt_code =
    (arb_lost & ~addressed) ? `TWBC_S_ARB_LOST :
    master ? (addr_phase ?
      (rd_dir ? (ack_ok ? `TWBC_S_MR_SLA_A : `TWBC_S_MR_SLA_N)
              : (ack_ok ? `TWBC_S_MT_SLA_A : `TWBC_S_MT_SLA_N)) :
      (rd_dir ? (sda_low ? `TWBC_S_MR_DAT_A : `TWBC_S_MR_DAT_N)
              : (ack_ok ? `TWBC_S_MT_DAT_A : `TWBC_S_MT_DAT_N))) :
    addr_phase ? (gc ? (arb_lost ? `TWBC_S_SR_ARB_GC : `TWBC_S_SR_GC) :
      rd_dir ? (arb_lost ? `TWBC_S_ST_ARB : `TWBC_S_ST_SLA)
             : (arb_lost ? `TWBC_S_SR_ARB : `TWBC_S_SR_SLA)) :
    rd_dir ? (ack_ok ? `TWBC_S_ST_DAT_A : `TWBC_S_ST_DAT_N) :
    gc ? (sda_low ? `TWBC_S_GC_DAT_A : `TWBC_S_GC_DAT_N)
       : (sda_low ? `TWBC_S_SR_DAT_A : `TWBC_S_SR_DAT_N);

  wire wr_ctrl  = reg_wr & (reg_addr == `TWBC_A_CTRL);
  wire wr_data  = reg_wr & (reg_addr == `TWBC_A_DATA);
  wire flag_clr = wr_ctrl & reg_wdata[`TWBC_C_FLAG];

  // software-owned settings
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      bit_rate <= `TWBC_RST_REG;
      ps_sel   <= 2'h0;
      own_addr <= `TWBC_RST_REG;
      {ack_en, sta, en, ie} <= 4'h0;
    end else begin
      if (reg_wr && reg_addr == `TWBC_A_BITRATE)
        bit_rate <= reg_wdata;
      if (reg_wr && reg_addr == `TWBC_A_STATUS)
        ps_sel <= reg_wdata[1:0];
      if (reg_wr && reg_addr == `TWBC_A_OWNADDR)
        own_addr <= reg_wdata;
      if (wr_ctrl) begin
        ack_en <= reg_wdata[`TWBC_C_ACKEN];
        sta    <= reg_wdata[`TWBC_C_STA];
        en     <= reg_wdata[`TWBC_C_EN];
        ie     <= reg_wdata[`TWBC_C_IE];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b)
      busy <= 1'b0;
    else if (!en || stop_det)
      busy <= 1'b0;
    else if (start_det)
      busy <= 1'b1;
  end

  // byte engine; flag writes below sit after the clear so a set wins
  always_ff @(posedge core_clk) begin
    if (!rst_b || !en) begin
      state      <= twbc_pkg::st_idle;
      flag       <= 1'b0;
      pend_code  <= `TWBC_S_NONE;
      shift_data <= `TWBC_RST_DATA;
      {master, addressed, addr_phase, rd_dir, arb_lost, gc} <= 6'h00;
      {ack_rx, scl_rel, sda_low, ph, rs, wake_req} <= 6'h04;
      bit_cnt    <= 4'h0;
      sto        <= 1'b0;
      if (rst_b && wr_ctrl)
        sto <= reg_wdata[`TWBC_C_STO];
    end else begin
      wake_req <= 1'b0;
      if (wr_data)
        shift_data <= reg_wdata;
      if (wr_ctrl)
        sto <= reg_wdata[`TWBC_C_STO];
      if (flag_clr)
        flag <= 1'b0;
      if (bus_err) begin
        flag      <= 1'b1;
        pend_code <= `TWBC_S_BUSERR;
        {master, addressed, sda_low, scl_rel} <= 4'h1;
        state     <= twbc_pkg::st_hold;
      end else if (stop_det && !master) begin
        if (addressed) begin
          flag      <= 1'b1;
          pend_code <= `TWBC_S_SR_STOP;
        end
        addressed <= 1'b0;
        sda_low   <= 1'b0;
        state     <= addressed ? twbc_pkg::st_hold : twbc_pkg::st_idle;
      end else if (start_det && !master) begin
        if (addressed) begin
          flag      <= 1'b1;
          pend_code <= `TWBC_S_SR_STOP;
        end
        {addressed, rd_dir, gc, sda_low} <= 4'h0;
        addr_phase <= 1'b1;
        bit_cnt    <= 4'h0;
        state      <= twbc_pkg::st_xfer;
      end else begin
        unique case (state)
          twbc_pkg::st_idle: begin
            if (!flag && sta && !busy && scl_f && sda_f) begin
              {master, scl_rel, sda_low, ph, rs} <= 5'h18;
              state <= twbc_pkg::st_start;
            end
          end
          twbc_pkg::st_start: begin
            if (tmr_end && !ph) begin
              sda_low <= 1'b1;
              ph      <= 1'b1;
            end else if (tmr_end) begin
              scl_rel    <= 1'b0;
              flag       <= 1'b1;
              pend_code  <= rs ? `TWBC_S_RSTART : `TWBC_S_START;
              addr_phase <= 1'b1;
              state      <= twbc_pkg::st_hold;
            end
          end
          twbc_pkg::st_rstart: begin
            if (tmr_end) begin
              {scl_rel, ph, rs} <= 3'h5;
              state <= twbc_pkg::st_start;
            end
          end
          twbc_pkg::st_stop: begin
            if (tmr_end && !ph) begin
              scl_rel <= 1'b1;
              ph      <= 1'b1;
            end else if (tmr_end) begin
              // flag stays clear after a master stop
              {sda_low, master, sto} <= 3'h0;
              state <= twbc_pkg::st_idle;
            end
          end
          twbc_pkg::st_hold: begin
            // nothing starts until the flag is cleared
            if (!flag) begin
              if (!master && !addressed) begin
                state <= twbc_pkg::st_idle;
              end else if (master && sta) begin
                sda_low <= 1'b0;
                state   <= twbc_pkg::st_rstart;
              end else if (master && sto) begin
                {sda_low, ph} <= 2'h2;
                state <= twbc_pkg::st_stop;
              end else begin
                bit_cnt <= 4'h0;
                sda_low <= is_tx & ~shift_data[7];
                if (master && addr_phase)
                  rd_dir <= shift_data[0];
                state <= twbc_pkg::st_xfer;
              end
            end
          end
          twbc_pkg::st_xfer: begin
            if (tmr_end)
              scl_rel <= ~scl_rel;
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt < 4'h8)
                shift_data <= {shift_data[6:0], sda_f};
              else
                ack_rx <= sda_f;
              if (arb_hit) begin
                // loser stays on as a receiver of the winner
                {master, arb_lost, scl_rel} <= 3'h3;
                rd_dir <= 1'b0;
              end
            end else if (scl_fall && bit_cnt == 4'h8) begin
              if (!master && addr_phase) begin
                if (match_ok) begin
                  {addressed, sda_low, wake_req} <= 3'h7;
                  gc     <= gc_hit & ~own_hit;
                  rd_dir <= shift_data[0];
                end else begin
                  sda_low <= 1'b0;
                  if (!arb_lost)
                    state <= twbc_pkg::st_idle;
                end
              end else begin
                sda_low <= ~is_tx & ack_en;
              end
            end else if (scl_fall && bit_cnt == 4'h9) begin
              flag       <= 1'b1;
              pend_code  <= evt_code;
              {sda_low, addr_phase, arb_lost} <= 3'h0;
              state      <= twbc_pkg::st_hold;
            end else if (scl_fall) begin
              sda_low <= is_tx & ~shift_data[7];
            end
          end
        endcase
      end
    end
  end

  // status code trails the flag by one cycle
  always_ff @(posedge core_clk) begin
    if (!rst_b)
      status_q <= `TWBC_S_NONE;
    else
      status_q <= flag ? pend_code : `TWBC_S_NONE;
  end

  // open-drain pins: only ever pull low
  wire scl_low = en & ((master & ~scl_rel & (state != twbc_pkg::st_idle)) |
                       (flag & (master | addressed)));
  wire [7:0] stat_show = flag ? status_q : `TWBC_S_NONE;
  wire [7:0] ctrl_rd = {flag, ack_en, sta, sto, 1'b0, en, 1'b0, ie};
  wire [7:0] rd_mux =
    (reg_addr == `TWBC_A_BITRATE) ? bit_rate :
    (reg_addr == `TWBC_A_STATUS)  ? {stat_show[7:3], 1'b0, ps_sel} :
    (reg_addr == `TWBC_A_OWNADDR) ? own_addr :
    (reg_addr == `TWBC_A_DATA)    ? shift_data :
    (reg_addr == `TWBC_A_CTRL)    ? ctrl_rd : 8'h00;

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      scl_oe_b  <= 1'b1;
      sda_oe_b  <= 1'b1;
      irq       <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      scl_oe_b  <= ~scl_low;
      sda_oe_b  <= ~(en & sda_low);
      irq       <= flag & ie & global_int_en;
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  flag_status_a: assert property ($rose(flag) |=> status_q == $past(pend_code))
    else $error("status not loaded one cycle after flag");
  none_code_a: assert property ((reg_rd && reg_addr == `TWBC_A_STATUS && !flag)
      |=> reg_rdata[7:3] == 5'h1f)
    else $error("status read without flag is not the no-status code");
  scl_hold_a: assert property (en && flag && (master || addressed) |=> !scl_oe_b)
    else $error("scl released while flag set");
  stop_noflag_a: assert property (state == twbc_pkg::st_stop && ph && tmr_end && !flag_clr
      |=> state == twbc_pkg::st_idle && !master && !flag)
    else $error("flag raised after master stop");
  arb_loss_a: assert property (state == twbc_pkg::st_xfer && scl_rise && arb_hit
      && !bus_err && !start_det && !stop_det |=> !master && arb_lost)
    else $error("arbitration loss not taken");
  spike_filter_a: assert property (!$stable(scl_f) |-> $past(hist[0][0]) == $past(hist[0][1]))
    else $error("scl filter passed a short pulse");
  hold_wait_a: assert property (state == twbc_pkg::st_hold && flag && !bus_err
      && !start_det && !stop_det |=> state == twbc_pkg::st_hold)
    else $error("operation started with flag set");
  half_period_a: assert property (state == twbc_pkg::st_xfer && master && tmr_end
      |-> tmr == half_m1 && !stall)
    else $error("scl phase ended before half period");
  slave_timer_a: assert property (!master |=> tmr == 15'h0000)
    else $error("bit-rate timer runs outside master operation");
  irq_gate_a: assert property (irq |-> $past(flag) && $past(ie) && $past(global_int_en))
    else $error("interrupt without all enables");

  start_sent_c: cover property (flag && pend_code == `TWBC_S_START);
  arb_lost_c: cover property ($rose(arb_lost));
  addressed_c: cover property ($rose(addressed));
  stop_done_c: cover property (state == twbc_pkg::st_stop ##1 state == twbc_pkg::st_idle);

endmodule

`default_nettype wire

// ### rtl/twbc_defs.svh
// register map, field positions, reset values, timing and status codes
`ifndef TWBC_DEFS_SVH
`define TWBC_DEFS_SVH

`define TWBC_A_BITRATE   3'h0
`define TWBC_A_STATUS    3'h1
`define TWBC_A_OWNADDR   3'h2
`define TWBC_A_DATA      3'h3
`define TWBC_A_CTRL      3'h4

`define TWBC_C_FLAG      7
`define TWBC_C_ACKEN     6
`define TWBC_C_STA       5
`define TWBC_C_STO       4
`define TWBC_C_EN        2
`define TWBC_C_IE        0
`define TWBC_O_GCE       0

`define TWBC_RST_REG     8'h00
`define TWBC_RST_DATA    8'hff

`define TWBC_CLK_NS      50
`define TWBC_SPIKE_NS    50
`define TWBC_SPIKE_CYC   ((`TWBC_SPIKE_NS + `TWBC_CLK_NS - 1) / `TWBC_CLK_NS)
`define TWBC_FILT_DEPTH  (`TWBC_SPIKE_CYC + 1)
`define TWBC_SYNC_LAT    (4 + `TWBC_FILT_DEPTH)
`define TWBC_HALF_BASE   15'h0008

`define TWBC_S_BUSERR    8'h00
`define TWBC_S_START     8'h08
`define TWBC_S_RSTART    8'h10
`define TWBC_S_MT_SLA_A  8'h18
`define TWBC_S_MT_SLA_N  8'h20
`define TWBC_S_MT_DAT_A  8'h28
`define TWBC_S_MT_DAT_N  8'h30
`define TWBC_S_ARB_LOST  8'h38
`define TWBC_S_MR_SLA_A  8'h40
`define TWBC_S_MR_SLA_N  8'h48
`define TWBC_S_MR_DAT_A  8'h50
`define TWBC_S_MR_DAT_N  8'h58
`define TWBC_S_SR_SLA    8'h60
`define TWBC_S_SR_ARB    8'h68
`define TWBC_S_SR_GC     8'h70
`define TWBC_S_SR_ARB_GC 8'h78
`define TWBC_S_SR_DAT_A  8'h80
`define TWBC_S_SR_DAT_N  8'h88
`define TWBC_S_GC_DAT_A  8'h90
`define TWBC_S_GC_DAT_N  8'h98
`define TWBC_S_SR_STOP   8'ha0
`define TWBC_S_ST_SLA    8'ha8
`define TWBC_S_ST_ARB    8'hb0
`define TWBC_S_ST_DAT_A  8'hb8
`define TWBC_S_ST_DAT_N  8'hc0
`define TWBC_S_NONE      8'hf8

`endif

// ### rtl/twbc_pkg.sv
// types shared by the two-wire bus controller
package twbc_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_start,
    st_rstart,
    st_xfer,
    st_hold,
    st_stop
  } twbc_state_t;
endpackage

// ### verification/tb.sv
// self-checking bench for the two-wire bus controller core
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [6:0] PEER = 7'h29;
  logic       core_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       gie = 1'b0;
  logic       m_scl = 1'b1;
  logic       m_sda = 1'b1;
  logic       spk_scl = 1'b1;
  logic       spk_sda = 1'b1;
  logic       p_ack = 1'b1;
  logic       wake_seen = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] got;
  logic       irq, wake_req, scl_o, scl_oe_b, sda_o, sda_oe_b, scl_rel, sda_rel;
  int         stretch = 0;
  int         err_count = 0;
  int         num_checks = 0;
  int         cyc = 0;
  int         last = 0;
  int         per = 0;
  int         hi = 0;
  logic [7:0] rst_t [8] = '{8'h00, 8'hf8, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] own_t [4] = '{8'h74, 8'h75, 8'h74, 8'h74};
  logic [7:0] adr_t [4] = '{8'h74, 8'h00, 8'h74, 8'h00};
  logic [7:0] ctl_t [4] = '{8'h44, 8'h44, 8'h04, 8'h44};
  logic [7:0] st_t  [4] = '{8'h60, 8'h70, 8'hf8, 8'hf8};
  logic       ack_t [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  // wired-and lines with pull-ups; spikes reach only the core's inputs
  wire        scl_w = (scl_oe_b | scl_o) & scl_rel & m_scl;
  wire        sda_w = (sda_oe_b | sda_o) & sda_rel & m_sda;

  twbc_core i_twbc_core (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_int_en(gie),
    .irq(irq), .wake_req(wake_req), .scl_i(scl_w & spk_scl), .scl_o(scl_o),
    .scl_oe_b(scl_oe_b), .sda_i(sda_w & spk_sda), .sda_o(sda_o), .sda_oe_b(sda_oe_b)
  );
  twbc_peer_slave i_twbc_peer_slave (
    .core_clk(core_clk), .scl(scl_w), .sda(sda_w), .addr(PEER), .ack_en(p_ack),
    .stretch(stretch), .scl_rel(scl_rel), .sda_rel(sda_rel), .got(got)
  );

  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  always @(posedge core_clk) if (wake_req === 1'b1) wake_seen <= 1'b1;
  // scl is timed on clock edges so launch-edge races cannot skew the counts
  logic       scl_d = 1'b1;
  int         rises = 0;
  always @(posedge core_clk) begin
    scl_d <= scl_w;
    if (scl_w && !scl_d) begin
      per <= cyc - last;
      last <= cyc;
      rises <= rises + 1;
    end
    if (!scl_w && scl_d)
      hi <= cyc - last;
  end

  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      err_count++;
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask
  // polls one control bit; a flag that never comes ends the run
  task poll(input int b, input logic v);
    logic [7:0] c;
    for (int i = 0; i < 4000; i++) begin
      rd(3'h4, c);
      if (c[b] === v) return;
    end
    err_count++;
    report_and_stop;
  endtask
  task step(input logic [7:0] ctl, input logic [7:0] code);
    logic [7:0] s;
    wr(3'h4, ctl);
    poll(7, 1'b1);
    rd(3'h1, s);
    chk(s & 8'hf8, code);
  endtask
  task stop_bus;
    logic [7:0] c;
    wr(3'h4, 8'h95);
    poll(4, 1'b0);
    rd(3'h4, c);
    chk({7'h00, c[7]}, 8'h00);
    chk({6'h00, scl_w, sda_w}, 8'h03);
  endtask
  task m_lvl(input logic c, input logic d);
    m_scl <= c;
    m_sda <= d;
    repeat (20) @(posedge core_clk);
  endtask
  task m_bit(input logic b, output logic s);
    m_lvl(1'b0, m_sda);
    m_lvl(1'b0, b);
    m_lvl(1'b1, b);
    s = sda_w;
  endtask
  task xfer(input logic [7:0] br, input logic [1:0] sel, output int p, output int h);
    wr(3'h0, br);
    wr(3'h1, {6'h00, sel});
    step(8'ha5, 8'h08);
    wr(3'h3, {PEER, 1'b0});
    step(8'h85, 8'h18);
    p = per;
    h = hi;
    stop_bus;
  endtask

  task t_regs;
    logic [7:0] c;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), c);
      chk(c, rst_t[a]);
    end
    wr(3'h6, 8'h55);
    rd(3'h6, c);
    chk(c, 8'h00);
    wr(3'h1, 8'hff);
    rd(3'h1, c);
    chk(c, 8'hfb);
  endtask
  task t_write;
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    step(8'ha5, 8'h08);
    repeat (50) @(posedge core_clk);
    chk({7'h00, scl_w}, 8'h00);
    chk({7'h00, irq}, 8'h00);
    gie <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({7'h00, irq}, 8'h01);
    wr(3'h4, 8'h24);
    repeat (2) @(posedge core_clk);
    chk({7'h00, irq}, 8'h00);
    gie <= 1'b0;
    wr(3'h3, {PEER, 1'b0});
    step(8'h85, 8'h18);
    chk(got, {PEER, 1'b0});
    wr(3'h3, 8'ha5);
    // 40 ns spikes placed across a clock edge, so one sample does see them
    fork
      begin
        @(posedge scl_w);
        #225 spk_sda = 1'b0;
        #40 spk_sda = 1'b1;
        @(posedge scl_w);
        #225 spk_scl = 1'b0;
        #40 spk_scl = 1'b1;
      end
    join_none
    step(8'h85, 8'h28);
    chk(got, 8'ha5);
    step(8'ha5, 8'h10);
    wr(3'h3, 8'h22);
    step(8'h85, 8'h20);
    stop_bus;
    p_ack <= 1'b0;
    step(8'ha5, 8'h08);
    wr(3'h3, {PEER, 1'b0});
    step(8'h85, 8'h18);
    wr(3'h3, 8'h3c);
    step(8'h85, 8'h30);
    stop_bus;
    p_ack <= 1'b1;
  endtask
  // a phantom master holds sda low; the core loses at its first 1 bit
  task t_arb;
    logic s;
    int   r0;
    step(8'ha5, 8'h08);
    wr(3'h3, {PEER, 1'b0});
    r0 = rises;
    m_sda <= 1'b0;
    fork
      step(8'h85, 8'h38);
      begin
        for (int i = 0; i < 4000 && rises < r0 + 2; i++) @(posedge core_clk);
        if (rises < r0 + 2) begin
          err_count++;
          report_and_stop;
        end
        repeat (6) @(posedge core_clk);
        for (int b = 0; b < 7; b++) m_bit(1'b0, s);
        m_lvl(1'b0, 1'b0);
        m_lvl(1'b1, 1'b0);
        m_lvl(1'b1, 1'b1);
      end
    join
    wr(3'h4, 8'h84);
    repeat (2) @(posedge core_clk);
    chk({6'h00, scl_oe_b, sda_oe_b}, 8'h03);
  endtask
  task t_rate;
    int p0, p1, h0, h1;
    for (int s = 0; s < 4; s++) begin
      xfer(8'h00, 2'(s), p0, h0);
      xfer(8'h01, 2'(s), p1, h1);
      chk(8'(p1 - p0), 8'(2 << (2 * s)));
    end
    chk({7'h00, p0 >= 16}, 8'h01);
    stretch = 100;
    xfer(8'h00, 2'h0, p1, h1);
    stretch = 0;
    chk(8'(h1), 8'(h0));
    chk({7'h00, p1 - p0 > 70}, 8'h01);
  endtask
  // the bench plays a remote master at 60 cycles a bit
  task t_slave;
    logic       s;
    logic [7:0] c;
    wr(3'h0, 8'hff);
    wr(3'h1, 8'h03);
    for (int k = 0; k < 4; k++) begin
      wr(3'h2, own_t[k]);
      wr(3'h4, ctl_t[k]);
      wake_seen <= 1'b0;
      m_lvl(1'b1, 1'b0);
      for (int b = 7; b >= 0; b--) m_bit(adr_t[k][b], s);
      m_bit(1'b1, s);
      m_lvl(1'b0, 1'b1);
      chk({7'h00, ~s}, {7'h00, ack_t[k]});
      chk({7'h00, wake_seen}, {7'h00, ack_t[k]});
      rd(3'h4, c);
      chk({7'h00, c[7]}, {7'h00, ack_t[k]});
      rd(3'h1, c);
      chk(c & 8'hf8, st_t[k]);
      wr(3'h4, 8'h80);
      m_lvl(1'b0, 1'b0);
      m_lvl(1'b1, 1'b0);
      m_lvl(1'b1, 1'b1);
    end
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs;
    t_write;
    t_arb;
    t_rate;
    t_slave;
    report_and_stop;
  end
endmodule
`default_nettype wire

// ### verification/twbc_peer_slave.sv
// behavioural bus slave: acks its own address, may nack data and stretch scl
`timescale 1ns/10ps
`default_nettype none
module twbc_peer_slave (
  // clock and wired bus levels
  input  wire logic       core_clk,
  input  wire logic       scl,
  input  wire logic       sda,
  // behaviour chosen by the bench
  input  wire logic [6:0] addr,
  input  wire logic       ack_en,
  input  wire logic [31:0] stretch,
  // releases (1 = let the pull-up win) and last byte taken
  output var  logic       scl_rel,
  output var  logic       sda_rel,
  output var  logic [7:0] got
);
  int         bitn = 9;
  logic       first = 1'b0;
  logic [7:0] shreg = 8'h00;
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
    got = 8'h00;
  end
  // start or repeated start: the next byte is an address
  always @(negedge sda) if (scl === 1'b1) begin
    bitn = -1;
    first = 1'b1;
  end
  always @(posedge scl) if (bitn >= 0 && bitn < 8) shreg = {shreg[6:0], sda};
  always @(negedge scl) begin
    bitn = bitn + 1;
    if (bitn == 8) begin
      got = shreg;
      sda_rel = first ? (shreg[7:1] != addr) : !ack_en;
    end else if (bitn >= 9) begin
      sda_rel = 1'b1;
      bitn = 0;
      first = 1'b0;
    end
    // release just after an edge so the core never samples a moving line
    if (stretch > 0) begin
      scl_rel = 1'b0;
      repeat (stretch) @(posedge core_clk);
      #1 scl_rel = 1'b1;
    end
  end
endmodule
`default_nettype wire
